// ### src/fsi_pkg.sv
package fsi_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_RECEIVE_INFORMATION = 8'h08;
  localparam logic [7:0] ADDR_SYNCHRONIZER_STATE = 8'h09;
  localparam logic [7:0] ADDR_PRIMARY_STATUS = 8'h0A;
  localparam logic [7:0] ADDR_SECONDARY_STATUS = 8'h0B;
  localparam logic [7:0] ADDR_SUMMARY_FIRST = 8'h0C;
  localparam logic [7:0] ADDR_SUMMARY_LAST = 8'h0E;
  localparam logic [7:0] ADDR_PRIMARY_IRQ_MASK = 8'h18;
  localparam logic [7:0] ADDR_SECONDARY_IRQ_MASK = 8'h19;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [5:0] RESET_SYNC_COUNT = 6'h00;

  // ----------------------------------------------------------------
  // Primary status bit positions
  // ----------------------------------------------------------------
  localparam int BIT_SIGNALING_ONES = 7;
  localparam int BIT_DISTANT_MF = 6;
  localparam int BIT_SIGNALING_ZEROS = 5;
  localparam int BIT_ELASTIC_SLIP = 4;
  localparam int BIT_UNFRAMED_ONES = 3;
  localparam int BIT_REMOTE_ALARM = 2;
  localparam int BIT_CARRIER_LOSS = 1;
  localparam int BIT_SYNC_LOSS = 0;

  // ----------------------------------------------------------------
  // Secondary status bit positions
  // ----------------------------------------------------------------
  localparam int BIT_RX_MF = 7;
  localparam int BIT_RX_ALIGN = 6;
  localparam int BIT_TX_MF = 5;
  localparam int BIT_ONE_SECOND = 4;
  localparam int BIT_TX_ALIGN = 3;
  localparam int BIT_TX_CLOCK_LOSS = 2;
  localparam int BIT_RX_CRC_MF = 1;
  localparam int BIT_PATTERN_DETECT = 0;

  // ----------------------------------------------------------------
  // Receive information bit positions
  // ----------------------------------------------------------------
  localparam int BIT_GAIN_HI = 7;
  localparam int BIT_GAIN_LO = 6;
  localparam int BIT_JITTER_TRIP = 5;
  localparam int BIT_ELASTIC_FULL = 4;
  localparam int BIT_ELASTIC_EMPTY = 3;
  localparam int BIT_CRC_RESYNC = 2;
  localparam int BIT_FRAME_RESYNC = 1;
  localparam int BIT_SIG_MF_RESYNC = 0;

  // ----------------------------------------------------------------
  // Flag behaviour classes: alarms follow level, levels latch on edge
  // ----------------------------------------------------------------
  localparam logic [7:0] PRIMARY_ALARM_BITS = 8'h0F;
  localparam logic [7:0] PRIMARY_LEVEL_BITS = 8'hE0;
  localparam logic [7:0] SECONDARY_ALARM_BITS = 8'h00;
  localparam logic [7:0] SECONDARY_LEVEL_BITS = 8'h05;
  localparam logic [7:0] INFO_ALARM_BITS = 8'hC0;
  localparam logic [7:0] INFO_LEVEL_BITS = 8'h00;

  // Synchronizer status layout
  localparam int SYNC_COUNT_WIDTH = 6;

endpackage

// ### src/fsi_status_bank.sv
`timescale 1ns/1ps
`default_nettype none
module fsi_status_bank
  import fsi_pkg::*;
#(
  parameter logic [7:0] ALARM_BITS = 8'h00,
  parameter logic [7:0] LEVEL_BITS = 8'h00,
  parameter bit IRQ_ENABLE = 1'b1
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] cond,
  input wire logic mask_wr,
  input wire logic [7:0] wdata,
  input wire logic rd,
  input wire logic [7:0] irq_mask,
  output logic [7:0] view,
  output logic pending
);

  logic [7:0] prev;
  logic [7:0] held;
  logic [7:0] last_mask;
  logic [7:0] irq;
  logic [7:0] rise;
  logic [7:0] fall;
  logic [7:0] pulse_bits;
  logic [7:0] flag_set;
  logic [7:0] irq_set;
  logic [7:0] read_clear;

  // ----------------------------------------------------------------
  // Edge and class decode
  // ----------------------------------------------------------------
  assign pulse_bits = ~(ALARM_BITS | LEVEL_BITS);
  assign rise = cond & ~prev;
  assign fall = ~cond & prev;
  // Alarms re-set every cycle while present; levels only on edge
  assign flag_set = (ALARM_BITS & cond) | (LEVEL_BITS & rise)
    | (pulse_bits & cond);
  assign irq_set = (ALARM_BITS & (rise | fall))
    | (LEVEL_BITS & rise)
    | (pulse_bits & cond);
  // A read clears only the bits the host asked for last
  assign read_clear = rd ? last_mask : RESET_BYTE;

  // Condition history for edge detection
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      prev <= RESET_BYTE;
    else
      prev <= cond;
  end

  // Hidden latch; set wins over a same-cycle read clear
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      held <= RESET_BYTE;
    else
      held <= (held & ~read_clear) | flag_set;
  end

  // Readable copy refreshed only where the mask has a one
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      view <= RESET_BYTE;
      last_mask <= RESET_BYTE;
    end
    else if (mask_wr)
    begin
      view <= (view & ~wdata) | (held & wdata);
      last_mask <= wdata;
    end
  end

  // Interrupt cause per bit, released by the read of its flag
  always_ff @(posedge clock)
  begin
    if (!rst_n || !IRQ_ENABLE)
      irq <= RESET_BYTE;
    else
      irq <= (irq & ~read_clear) | irq_set;
  end

  // Mask zero blocks the bit from the pin
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      pending <= 1'b0;
    else
      pending <= |(irq & irq_mask);
  end

endmodule
`default_nettype wire

// ### src/fsi_status_top.sv
`timescale 1ns/1ps
`default_nettype none
module fsi_status_top
  import fsi_pkg::*;
#(
  parameter int NUM_PORTS = 4
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic host_cs,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [1:0] host_port,
  input wire logic [7:0] host_addr,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  output logic int_n,
  input wire logic [NUM_PORTS*8-1:0] primary_cond,
  input wire logic [NUM_PORTS*8-1:0] secondary_cond,
  input wire logic [NUM_PORTS*8-1:0] info_cond,
  input wire logic [NUM_PORTS-1:0] frame_align_search,
  input wire logic [NUM_PORTS-1:0] signaling_mf_search,
  input wire logic [NUM_PORTS-1:0] crc_mf_search,
  input wire logic [NUM_PORTS-1:0] crc_search_timeout,
  input wire logic [NUM_PORTS-1:0] crc_sync_found,
  input wire logic [NUM_PORTS-1:0] crc_mode_enable
);

  import fsi_pkg::*;

  // ----------------------------------------------------------------
  // Host access decode
  // ----------------------------------------------------------------
  logic wr_strobe;
  logic rd_strobe;
  logic hit_primary;
  logic hit_secondary;
  logic hit_info;
  logic hit_sync;
  logic hit_summary;
  logic hit_pmask;
  logic hit_smask;

  assign wr_strobe = host_cs && host_wr;
  assign rd_strobe = host_cs && host_rd && !host_wr;
  assign hit_primary = host_addr == ADDR_PRIMARY_STATUS;
  assign hit_secondary = host_addr == ADDR_SECONDARY_STATUS;
  assign hit_info = host_addr == ADDR_RECEIVE_INFORMATION;
  assign hit_sync = host_addr == ADDR_SYNCHRONIZER_STATE;
  // Any address from 0x0C to 0x0E shows the summary
  assign hit_summary = (host_addr >= ADDR_SUMMARY_FIRST)
    && (host_addr <= ADDR_SUMMARY_LAST);
  assign hit_pmask = host_addr == ADDR_PRIMARY_IRQ_MASK;
  assign hit_smask = host_addr == ADDR_SECONDARY_IRQ_MASK;

  // ----------------------------------------------------------------
  // Per-port storage views
  // ----------------------------------------------------------------
  logic [7:0] primary_view [NUM_PORTS];
  logic [7:0] secondary_view [NUM_PORTS];
  logic [7:0] info_view [NUM_PORTS];
  logic [7:0] primary_irq_mask [NUM_PORTS];
  logic [7:0] secondary_irq_mask [NUM_PORTS];
  logic [7:0] synchronizer_state_reg [NUM_PORTS];
  logic [SYNC_COUNT_WIDTH-1:0] crc_sync_count [NUM_PORTS];
  logic [NUM_PORTS-1:0] primary_pending;
  logic [NUM_PORTS-1:0] secondary_pending;
  logic [7:0] summary;

  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p = p + 1)
    begin : g_port
      logic sel;
      assign sel = host_port == 2'(p);

      // Primary status: line alarms, signaling events, slip
      fsi_status_bank #(
        .ALARM_BITS(PRIMARY_ALARM_BITS),
        .LEVEL_BITS(PRIMARY_LEVEL_BITS),
        .IRQ_ENABLE(1'b1)
      ) u_primary (
        .clock(clock),
        .rst_n(rst_n),
        .cond(primary_cond[p*8 +: 8]),
        .mask_wr(wr_strobe && sel && hit_primary),
        .wdata(host_wdata),
        .rd(rd_strobe && sel && hit_primary),
        .irq_mask(primary_irq_mask[p]),
        .view(primary_view[p]),
        .pending(primary_pending[p])
      );

      // Secondary status: frame timing events and conditions
      fsi_status_bank #(
        .ALARM_BITS(SECONDARY_ALARM_BITS),
        .LEVEL_BITS(SECONDARY_LEVEL_BITS),
        .IRQ_ENABLE(1'b1)
      ) u_secondary (
        .clock(clock),
        .rst_n(rst_n),
        .cond(secondary_cond[p*8 +: 8]),
        .mask_wr(wr_strobe && sel && hit_secondary),
        .wdata(host_wdata),
        .rd(rd_strobe && sel && hit_secondary),
        .irq_mask(secondary_irq_mask[p]),
        .view(secondary_view[p]),
        .pending(secondary_pending[p])
      );

      // Receive information: gain band latched while present, rest pulse
      fsi_status_bank #(
        .ALARM_BITS(INFO_ALARM_BITS),
        .LEVEL_BITS(INFO_LEVEL_BITS),
        .IRQ_ENABLE(1'b0)
      ) u_info (
        .clock(clock),
        .rst_n(rst_n),
        .cond(info_cond[p*8 +: 8]),
        .mask_wr(wr_strobe && sel && hit_info),
        .wdata(host_wdata),
        .rd(rd_strobe && sel && hit_info),
        .irq_mask(RESET_BYTE),
        .view(info_view[p]),
        .pending()
      );

      // Interrupt mask registers, written directly by the host
      always_ff @(posedge clock)
      begin
        if (!rst_n)
        begin
          primary_irq_mask[p] <= RESET_BYTE;
          secondary_irq_mask[p] <= RESET_BYTE;
        end
        else if (wr_strobe && sel)
        begin
          if (hit_pmask)
            primary_irq_mask[p] <= host_wdata;
          if (hit_smask)
            secondary_irq_mask[p] <= host_wdata;
        end
      end

      // CRC sync counter; disable and lock take priority
      always_ff @(posedge clock)
      begin
        if (!rst_n)
          crc_sync_count[p] <= RESET_SYNC_COUNT;
        else if (crc_sync_found[p] || !crc_mode_enable[p])
          crc_sync_count[p] <= RESET_SYNC_COUNT;
        else if (crc_search_timeout[p])
          crc_sync_count[p] <= crc_sync_count[p] + 6'h01;
      end

      // Live synchronizer view; counter bit 1 is not exposed
      assign synchronizer_state_reg[p] = {
        crc_sync_count[p][5:2],
        crc_sync_count[p][0],
        frame_align_search[p],
        signaling_mf_search[p],
        crc_mf_search[p]
      };

      // Summary pairs per port: primary low, secondary high
      assign summary[2*p] = primary_pending[p];
      assign summary[2*p+1] = secondary_pending[p];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read data, one cycle after the read strobe
  // ----------------------------------------------------------------
  logic [7:0] next_rdata;

  // Unmapped addresses answer zero
  always_comb
  begin
    next_rdata = RESET_BYTE;
    if (hit_primary)
      next_rdata = primary_view[host_port];
    else if (hit_secondary)
      next_rdata = secondary_view[host_port];
    else if (hit_info)
      next_rdata = info_view[host_port];
    else if (hit_sync)
      next_rdata = synchronizer_state_reg[host_port];
    else if (hit_summary)
      next_rdata = summary;
    else if (hit_pmask)
      next_rdata = primary_irq_mask[host_port];
    else if (hit_smask)
      next_rdata = secondary_irq_mask[host_port];
  end

  // Read data holds until the next read
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      host_rdata <= RESET_BYTE;
    else if (rd_strobe)
      host_rdata <= next_rdata;
  end

  // ----------------------------------------------------------------
  // Shared interrupt pin
  // ----------------------------------------------------------------
  // Registered so the pin never glitches during decode
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      int_n <= 1'b1;
    else
      int_n <= ~(|summary);
  end

endmodule
`default_nettype wire

// ### tb/fsi_status_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Port-level checks
// ----
module fsi_status_assertions #(
  parameter int NUM_PORTS = 4
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic host_cs,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [1:0] host_port,
  input wire logic [7:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata,
  input wire logic int_n,
  input wire logic [NUM_PORTS*8-1:0] primary_cond,
  input wire logic [NUM_PORTS-1:0] frame_align_search
);
  logic rd_take;
  logic sum_rd;
  logic [7:0] mask0;
  // Decoded reads
  assign rd_take = host_cs && host_rd && !host_wr;
  assign sum_rd = rd_take && host_addr >= 8'h0C && host_addr <= 8'h0E;
  // Port 0 primary mask shadow, so alarm checks gate like the pin
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      mask0 <= 8'h00;
    else if (host_cs && host_wr && host_port == 2'd0 && host_addr == 8'h18)
      mask0 <= host_wdata;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_rst; disable iff (1'b0) !rst_n |=> int_n; endproperty
  a_rst: assert property (p_rst)
    else $error("int_n low after reset");
  property p_hold; !rd_take [*2] |=> $stable(host_rdata); endproperty
  a_hold: assert property (p_hold)
    else $error("read data moved without a read");
  property p_unmap; rd_take && host_addr == 8'h20 |=> host_rdata == 0; endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not zero");
  property p_live;
    rd_take && host_addr == 8'h09 && host_port == 2'd0
      |=> host_rdata[2] == $past(frame_align_search[0]);
  endproperty
  a_live: assert property (p_live)
    else $error("search bit not live");
  property p_mask;
    rd_take && host_addr == 8'h18 && host_port == 2'd0 |=> host_rdata == mask0;
  endproperty
  a_mask: assert property (p_mask)
    else $error("mask readback wrong");
  property p_alarm; $changed(primary_cond[0]) && mask0[0] |-> ##[1:5] !int_n;
  endproperty
  a_alarm: assert property (p_alarm)
    else $error("alarm change without interrupt");
  property p_quiet; sum_rd ##1 int_n |-> host_rdata == 8'h00; endproperty
  a_quiet: assert property (p_quiet)
    else $error("summary busy while int_n high");
  property p_busy; sum_rd ##1 !int_n |-> host_rdata != 8'h00; endproperty
  a_busy: assert property (p_busy)
    else $error("summary empty while int_n low");
  c_alarm: cover property ($changed(primary_cond[0]) && mask0[0]);
  c_busy: cover property (sum_rd ##1 !int_n);
  c_live: cover property (rd_take && host_addr == 8'h09);
endmodule
`default_nettype wire

// ### tb/fsi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Host processor on the parallel port
// ----
module fsi_host_model
(
  input wire logic clock,
  input wire logic [7:0] host_rdata,
  output logic host_cs,
  output logic host_wr,
  output logic host_rd,
  output logic [1:0] host_port,
  output logic [7:0] host_addr,
  output logic [7:0] host_wdata
);
  // Idle bus from time zero
  initial
  begin
    {host_cs, host_wr, host_rd, host_port, host_addr, host_wdata} = '0;
  end
  // One strobe over one rising edge; released address and data lines flip so stale
  // values are never mistaken for a held bus
  task automatic acc(input logic w, input logic [1:0] p,
    input logic [7:0] a, input logic [7:0] wd);
    @(negedge clock);
    {host_cs, host_wr, host_rd} = {1'b1, w, !w};
    {host_port, host_addr, host_wdata} = {p, a, wd};
    @(negedge clock);
    {host_cs, host_wr, host_rd} = 3'b000;
    {host_addr, host_wdata} = ~{host_addr, host_wdata};
  endtask
  // Read; data taken a cycle late since it stands until the next read
  task automatic bus_rd(input logic [1:0] p, input logic [7:0] a,
    output logic [7:0] d);
    acc(1'b0, p, a, 8'h00);
    @(negedge clock);
    d = host_rdata;
  endtask
  // Clearing sequence for latched registers
  task automatic poll(input logic [1:0] p, input logic [7:0] a,
    input logic [7:0] m, output logic [7:0] d);
    acc(1'b1, p, a, m);
    bus_rd(p, a, d);
    acc(1'b1, p, a, d & m);
  endtask
endmodule
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Bench
// ----
module tb_top;
  import fsi_pkg::*;
  logic clock;
  logic rst_n;
  logic host_cs, host_wr, host_rd, int_n;
  logic [1:0] host_port;
  logic [7:0] host_addr, host_wdata, host_rdata, d;
  logic [31:0] primary_cond, secondary_cond, info_cond;
  logic [3:0] frame_align_search, signaling_mf_search, crc_mf_search;
  logic [3:0] crc_search_timeout, crc_sync_found, crc_mode_enable;
  int err_total = 0;
  int compares = 0;
  int cycles = 0;
  // Port, info pulse, poll mask, expected read
  localparam logic [25:0] ROWS [8] = '{
    {2'd0, 8'h20, 8'hFF, 8'h20}, {2'd1, 8'h10, 8'hFF, 8'h10},
    {2'd2, 8'h08, 8'hFF, 8'h08}, {2'd3, 8'h04, 8'hFF, 8'h04},
    {2'd0, 8'h02, 8'hFF, 8'h02}, {2'd1, 8'h01, 8'hFF, 8'h01},
    {2'd2, 8'h24, 8'h04, 8'h04}, {2'd0, 8'h00, 8'hFF, 8'h00}};
  fsi_status_top #(
    .NUM_PORTS(4)
  ) uut (
    .clock(clock),
    .rst_n(rst_n),
    .host_cs(host_cs),
    .host_wr(host_wr),
    .host_rd(host_rd),
    .host_port(host_port),
    .host_addr(host_addr),
    .host_wdata(host_wdata),
    .host_rdata(host_rdata),
    .int_n(int_n),
    .primary_cond(primary_cond),
    .secondary_cond(secondary_cond),
    .info_cond(info_cond),
    .frame_align_search(frame_align_search),
    .signaling_mf_search(signaling_mf_search),
    .crc_mf_search(crc_mf_search),
    .crc_search_timeout(crc_search_timeout),
    .crc_sync_found(crc_sync_found),
    .crc_mode_enable(crc_mode_enable)
  );
  fsi_host_model host (
    .clock(clock),
    .host_rdata(host_rdata),
    .host_cs(host_cs),
    .host_wr(host_wr),
    .host_rd(host_rd),
    .host_port(host_port),
    .host_addr(host_addr),
    .host_wdata(host_wdata)
  );
  // Clock
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Hang guard
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      err_total++;
      results();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic irq(input logic exp);
    check({7'h00, int_n}, {7'h00, exp});
  endtask
  // Timeout pulses on port 0, then a live read without mask write
  task automatic synchronizer_state(input int n, input logic [7:0] exp);
    repeat (n)
    begin
      @(negedge clock);
      crc_search_timeout = 4'h1;
      @(negedge clock);
      crc_search_timeout = 4'h0;
    end
    host.bus_rd(2'd0, ADDR_SYNCHRONIZER_STATE, d);
    check(d, exp);
  endtask
  task automatic results();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Main sequence; inputs move on falling edges
  initial
  begin
    rst_n = 1'b0;
    {primary_cond, secondary_cond, info_cond} = '0;
    {frame_align_search, signaling_mf_search, crc_mf_search} = 12'h101;
    {crc_search_timeout, crc_sync_found, crc_mode_enable} = 12'h00F;
    idle(2);
    rst_n = 1'b1;
    irq(1'b1);
    host.bus_rd(2'd0, ADDR_PRIMARY_IRQ_MASK, d);
    check(d, 8'h00);
    host.bus_rd(2'd0, 8'h20, d);
    foreach (ROWS[i])
    begin
      @(negedge clock);
      info_cond[ROWS[i][25:24]*8 +: 8] = ROWS[i][23:16];
      @(negedge clock);
      info_cond = '0;
      host.poll(ROWS[i][25:24], ADDR_RECEIVE_INFORMATION, ROWS[i][15:8], d);
      check(d, ROWS[i][7:0]);
    end
    irq(1'b1);
    for (int g = 0; g < 4; g++)
    begin
      info_cond[15:14] = g[1:0];
      // Band latches; the first poll drops the band seen before the change
      repeat (2)
        host.poll(2'd1, ADDR_RECEIVE_INFORMATION, 8'hC0, d);
      check(d, {g[1:0], 6'h00});
    end
    synchronizer_state(6, 8'h15);
    host.acc(1'b1, 2'd0, ADDR_SYNCHRONIZER_STATE, 8'hFF);
    synchronizer_state(57, 8'hFD);
    synchronizer_state(1, 8'h05);
    synchronizer_state(3, 8'h0D);
    crc_sync_found = 4'h1;
    idle(1);
    crc_sync_found = 4'h0;
    synchronizer_state(0, 8'h05);
    synchronizer_state(4, 8'h15);
    crc_mode_enable = 4'h0;
    synchronizer_state(0, 8'h05);
    host.acc(1'b1, 2'd0, ADDR_PRIMARY_IRQ_MASK, 8'hFF);
    host.acc(1'b1, 2'd2, ADDR_PRIMARY_IRQ_MASK, 8'hFF);
    host.bus_rd(2'd0, ADDR_PRIMARY_IRQ_MASK, d);
    primary_cond = 32'h0010_0010;
    idle(1);
    primary_cond = '0;
    idle(5);
    irq(1'b0);
    host.bus_rd(2'd1, 8'h0D, d);
    check(d, 8'h11);
    host.poll(2'd2, ADDR_PRIMARY_STATUS, 8'h10, d);
    check(d, 8'h10);
    idle(5);
    irq(1'b0);
    host.poll(2'd0, ADDR_PRIMARY_STATUS, 8'h10, d);
    idle(5);
    irq(1'b1);
    primary_cond[20] = 1'b1;
    idle(1);
    primary_cond = '0;
    idle(5);
    irq(1'b0);
    host.poll(2'd2, ADDR_PRIMARY_STATUS, 8'h10, d);
    primary_cond[0] = 1'b1;
    idle(5);
    irq(1'b0);
    host.poll(2'd0, ADDR_PRIMARY_STATUS, 8'h01, d);
    check(d, 8'h01);
    idle(5);
    irq(1'b1);
    host.poll(2'd0, ADDR_PRIMARY_STATUS, 8'h01, d);
    check(d, 8'h01);
    primary_cond[0] = 1'b0;
    idle(5);
    irq(1'b0);
    host.poll(2'd0, ADDR_PRIMARY_STATUS, 8'h01, d);
    host.poll(2'd0, ADDR_PRIMARY_STATUS, 8'h01, d);
    check(d, 8'h00);
    host.acc(1'b1, 2'd3, ADDR_SECONDARY_IRQ_MASK, 8'hFF);
    secondary_cond[24] = 1'b1;
    idle(5);
    irq(1'b0);
    host.bus_rd(2'd0, 8'h0E, d);
    check(d, 8'h80);
    host.poll(2'd3, ADDR_SECONDARY_STATUS, 8'h01, d);
    idle(8);
    irq(1'b1);
    secondary_cond[24] = 1'b0;
    idle(3);
    secondary_cond[24] = 1'b1;
    idle(5);
    irq(1'b0);
    host.poll(2'd3, ADDR_SECONDARY_STATUS, 8'h01, d);
    primary_cond[12] = 1'b1;
    idle(1);
    primary_cond = '0;
    idle(5);
    irq(1'b1);
    results();
  end
endmodule
bind fsi_status_top fsi_status_assertions #(
  .NUM_PORTS(NUM_PORTS)
) u_chk (
  .clock(clock),
  .rst_n(rst_n),
  .host_cs(host_cs),
  .host_wr(host_wr),
  .host_rd(host_rd),
  .host_port(host_port),
  .host_addr(host_addr),
  .host_wdata(host_wdata),
  .host_rdata(host_rdata),
  .int_n(int_n),
  .primary_cond(primary_cond),
  .frame_align_search(frame_align_search)
);
`default_nettype wire
